// File: pkg/cfg_fwd_defs.svh
// offsets, field positions, reset values and timing counts of the
// configuration chain forwarder; assumes a 20 MHz fabric clock.
`ifndef CFG_FWD_DEFS_SVH
`define CFG_FWD_DEFS_SVH

// ************************************************************
// register byte addresses
// ************************************************************
`define CFF_ADDR_W        12
`define CFF_CTRL_ADDR     12'h000
`define CFF_STAT_ADDR     12'h004
`define CFF_IRQ_ADDR      12'h008
`define CFF_MASK_ADDR     12'h00c

// ************************************************************
// control fields
// ************************************************************
`define CFF_CTRL_W        7
`define CFF_C_EN          0
`define CFF_C_DAISY       1
`define CFF_C_PARALLEL    2
`define CFF_C_COMPRESS    3
`define CFF_C_ENCRYPT     4
`define CFF_C_FABRIC      5
`define CFF_C_HB_UNUSED   6
`define CFF_C_RESTART     8
`define CFF_C_UPDATE      9
`define CFF_C_LEGACY_UPG  10
`define CFF_CTRL_RST      7'h00

// ************************************************************
// interrupt status / mask fields
// ************************************************************
`define CFF_IRQ_W         6
`define CFF_I_WORD        0
`define CFF_I_SLV_DONE    1
`define CFF_I_CFG_ERR     2
`define CFF_I_OVERRUN     3
`define CFF_I_REJECT      4
`define CFF_I_UPG_REFUSE  5
`define CFF_IRQ_RST       6'h00

// ************************************************************
// timing
// ************************************************************
`define CFF_CLK_PERIOD_NS 50
`define CFF_RESTART_LOW_NS 2000
`define CFF_CFG_HALF_NS   100
`define CFF_RESTART_LOW_CYC \
  ((`CFF_RESTART_LOW_NS + `CFF_CLK_PERIOD_NS - 1) / `CFF_CLK_PERIOD_NS)
`define CFF_CFG_HALF_CYC \
  ((`CFF_CFG_HALF_NS + `CFF_CLK_PERIOD_NS - 1) / `CFF_CLK_PERIOD_NS)

`endif

// File: pkg/cfg_fwd_pkg.sv
// types shared by the configuration chain forwarder files;
// assumes cfg_fwd_defs.svh is on the include path.
`include "cfg_fwd_defs.svh"

package cfg_fwd_pkg;

  typedef enum logic [2:0] {
    S_IDLE,
    S_RESTART,
    S_WAIT_READY,
    S_WAIT_FABRIC,
    S_RUN
  } fwd_state_t;

  typedef struct packed {
    fwd_state_t                st;
    logic [15:0]               cnt;
    logic [`CFF_CTRL_W-1:0]    ctrl;
    logic                      en_prev;
    logic [`CFF_IRQ_W-1:0]     irq;
    logic [`CFF_IRQ_W-1:0]     mask;
    logic [7:0]                word;
    logic                      wv;
    logic                      ep_clk_prev;
    logic                      done_prev;
    logic                      upd;
    logic                      restart_n;
    logic                      hb_rst;
    logic [31:0]               prdata;
    logic                      pslverr;
  } fwd_regs_t;

endpackage

// File: rtl/pcie_config_chain_forwarder.sv
// configuration chain forwarder: takes image words from the
// endpoint side and passes them on to passive slaves or to the
// root-complex link, with an apb register file and interrupt.
// assumes the endpoint link pins, slave status and done pins and the reset pin are asynchronous,
// and that the root-complex core and own config engine share clk.
`timescale 1ns/1ps
`include "cfg_fwd_defs.svh"

//
// Contract
// - mixed chain fetches host words and forwards them passively to slaves.
// - slave config clock and data appear on general-purpose outputs.
// - drive slave restart line and chain-enable line as outputs.
// - endpoint faces upstream, root complex faces next device.
// - in daisy chain own restart, enable, status, done pins stay independent.
// - start configuring next device only after own fabric is in user mode.
// - daisy words from host go out over the root-complex link.
// - fabric load complete low while loading, high when complete.
// - hold transceivers and hard block in reset while reset pin low.
// - unused hard block frees the reset pin as a user input.
// - compression applies to the fabric image only, never to periphery.
// - encryption applies to fabric image only; periphery stays plain.
// - encrypted fabric image is decrypted with a preprogrammed key.
// - legacy remote upgrade refused; upgrade by fabric update instead.
// - fabric update drives load complete low; restart stays high; code pulses it low on a mixed-chain enable or a restart sent with update.
// - shared slave status low forces slaves to reinitialise and reload.
module pcie_config_chain_forwarder
  import cfg_fwd_pkg::*;
#(
  parameter int DW           = 8,
  parameter int RESTART_CYC  = `CFF_RESTART_LOW_CYC,
  parameter int CFG_HALF_CYC = `CFF_CFG_HALF_CYC
) (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [`CFF_ADDR_W-1:0] paddr,
  input  wire logic [31:0]          pwdata,
  output logic [31:0]               prdata,
  output logic                      pready,
  output logic                      pslverr,
  output logic                      irq,
  input  wire logic                 ep_clk,
  input  wire logic                 ep_valid,
  input  wire logic [DW-1:0]        ep_data,
  output logic                      ep_ready,
  output logic [DW-1:0]             rc_tx_data,
  output logic                      rc_tx_valid,
  input  wire logic                 rc_tx_ready,
  output logic                      slave_cfg_clk_out,
  output logic [DW-1:0]             slave_data_out,
  output logic                      slave_restart_out_n,
  output logic                      slave_enable_out_n,
  input  wire logic                 cfg_status_n,
  input  wire logic                 cfg_complete,
  input  wire logic                 own_fabric_done,
  input  wire logic                 fabric_update_done,
  input  wire logic                 key_valid,
  output logic                      decrypt_en,
  output logic                      fabric_load_complete,
  input  wire logic                 pcie_fundamental_reset_n,
  output logic                      hard_block_rst,
  output logic                      user_pin_in
);

  localparam int SW = DW + 5;

  fwd_regs_t        r_q;
  fwd_regs_t        r_d;
  logic [SW-1:0]    pin_s;
  logic [DW-1:0]    ep_data_s;
  logic             ep_clk_s;
  logic             ep_valid_s;
  logic             status_n_s;
  logic             complete_s;
  logic             perst_s;
  logic             ser_ready;
  logic             ser_load;
  logic             daisy;
  logic             running;
  logic             apb_wr;
  logic             apb_setup;

  initial
  begin
    if (DW != 8 || RESTART_CYC < 1 || RESTART_CYC > 65535)
      $error("forwarder: DW must be 8 and RESTART_CYC in range");
  end

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  sync2 #(
    .WIDTH (SW)
  ) u_sync (
    .clk (clk),
    .rst (rst),
    .d   ({pcie_fundamental_reset_n, cfg_complete, cfg_status_n,
           ep_valid, ep_clk, ep_data}),
    .q   (pin_s)
  );

  assign ep_data_s  = pin_s[DW-1:0];
  assign ep_clk_s   = pin_s[DW];
  assign ep_valid_s = pin_s[DW+1];
  assign status_n_s = pin_s[DW+2];
  assign complete_s = pin_s[DW+3];
  assign perst_s    = pin_s[DW+4];

  // ************************************************************
  // passive slave output
  // ************************************************************
  assign daisy    = r_q.ctrl[`CFF_C_DAISY];
  assign running  = (r_q.st == S_RUN);
  // status low means the slaves are not accepting data
  assign ser_load = r_q.wv && running && !daisy && status_n_s;

  word_serializer #(
    .W    (DW),
    .HALF (CFG_HALF_CYC)
  ) u_ser (
    .clk        (clk),
    .rst        (rst),
    .parallel   (r_q.ctrl[`CFF_C_PARALLEL]),
    .load_valid (ser_load),
    .load_data  (r_q.word),
    .load_ready (ser_ready),
    .cfg_clk    (slave_cfg_clk_out),
    .cfg_data   (slave_data_out)
  );

  // ************************************************************
  // outputs
  // ************************************************************
  assign apb_setup   = psel && !penable;
  assign apb_wr      = psel && penable && pwrite;
  assign pready      = 1'b1;
  assign prdata      = r_q.prdata;
  assign pslverr     = r_q.pslverr;
  assign irq         = |(r_q.irq & r_q.mask);
  assign ep_ready    = running && !r_q.wv;
  assign rc_tx_data  = r_q.word;
  assign rc_tx_valid = r_q.wv && running && daisy;
  // in the daisy chain the slave pins stay idle and unshared
  assign slave_restart_out_n = daisy ? 1'b1 : r_q.restart_n;
  assign slave_enable_out_n  =
    (daisy || r_q.st == S_IDLE) ? 1'b1 : 1'b0;
  assign decrypt_en  = running && r_q.ctrl[`CFF_C_ENCRYPT]
                       && r_q.ctrl[`CFF_C_FABRIC];
  assign fabric_load_complete = own_fabric_done && !r_q.upd;
  assign hard_block_rst = r_q.hb_rst;
  assign user_pin_in    = perst_s;

  // ************************************************************
  // next state
  // ************************************************************
  always_comb
  begin
    logic [`CFF_IRQ_W-1:0] ev;
    logic                  bad;
    logic                  accept;
    ev     = '0;
    bad    = 1'b0;
    accept = 1'b0;
    r_d    = r_q;

    r_d.ep_clk_prev = ep_clk_s;
    r_d.done_prev   = complete_s;
    r_d.en_prev     = r_q.ctrl[`CFF_C_EN];
    // pin is only a plain input when the hard block is unused
    r_d.hb_rst = r_q.ctrl[`CFF_C_HB_UNUSED] || !perst_s;

    // word capture on the endpoint link clock rising edge
    if (ep_clk_s && !r_q.ep_clk_prev && ep_valid_s && running)
    begin
      if (r_q.wv)
        ev[`CFF_I_OVERRUN] = 1'b1;
      else
      begin
        r_d.word = ep_data_s;
        r_d.wv   = 1'b1;
      end
    end

    // hand-off to the slaves or to the root-complex link
    if (ser_load && ser_ready)
      accept = 1'b1;
    if (rc_tx_valid && rc_tx_ready)
      accept = 1'b1;
    if (accept)
    begin
      r_d.wv = 1'b0;
      ev[`CFF_I_WORD] = 1'b1;
    end

    if (!daisy && complete_s && !r_q.done_prev)
      ev[`CFF_I_SLV_DONE] = 1'b1;

    // periphery images must be plain, and encryption needs a key
    bad = (!r_q.ctrl[`CFF_C_FABRIC]
           && (r_q.ctrl[`CFF_C_COMPRESS] || r_q.ctrl[`CFF_C_ENCRYPT]))
          || (r_q.ctrl[`CFF_C_ENCRYPT] && !key_valid);

    unique case (r_q.st)
      S_IDLE:
      begin
        r_d.restart_n = 1'b1;
        r_d.wv        = 1'b0;
        if (r_q.ctrl[`CFF_C_EN] && !r_q.en_prev)
        begin
          if (bad)
            ev[`CFF_I_REJECT] = 1'b1;
          else if (daisy)
            r_d.st = S_WAIT_FABRIC;
          else
          begin
            r_d.st        = S_RESTART;
            r_d.restart_n = 1'b0;
            r_d.cnt       = 16'(RESTART_CYC - 1);
          end
        end
      end
      S_RESTART:
      begin
        if (r_q.cnt == 16'h0000)
        begin
          r_d.restart_n = 1'b1;
          r_d.st        = S_WAIT_READY;
        end
        else
          r_d.cnt = r_q.cnt - 16'h0001;
      end
      S_WAIT_READY:
      begin
        if (status_n_s)
          r_d.st = S_RUN;
      end
      S_WAIT_FABRIC:
      begin
        if (own_fabric_done && !r_q.upd)
          r_d.st = S_RUN;
      end
      S_RUN:
      begin
        // slaves signal an error by holding status low; the word
        // in flight is lost and the image must be resent
        if (!daisy && !status_n_s)
        begin
          ev[`CFF_I_CFG_ERR] = 1'b1;
          r_d.wv = 1'b0;
          r_d.st = S_WAIT_READY;
        end
      end
    endcase

    // ************************************************************
    // apb slave
    // ************************************************************
    r_d.pslverr = 1'b0;
    if (apb_setup)
    begin
      r_d.prdata  = 32'h0000_0000;
      unique case (paddr)
        `CFF_CTRL_ADDR: r_d.prdata = 32'(r_q.ctrl);
        `CFF_STAT_ADDR: r_d.prdata = 32'({ser_ready, r_q.wv, r_q.upd,
                                         key_valid, perst_s, complete_s,
                                         status_n_s, fabric_load_complete,
                                         r_q.st});
        `CFF_IRQ_ADDR:  r_d.prdata = 32'(r_q.irq);
        `CFF_MASK_ADDR: r_d.prdata = 32'(r_q.mask);
        default:        r_d.pslverr = 1'b1;
      endcase
    end
    else if (psel && penable)
      r_d.pslverr = r_q.pslverr;

    if (apb_wr)
    begin
      unique case (paddr)
        `CFF_CTRL_ADDR:
        begin
          r_d.ctrl = pwdata[`CFF_CTRL_W-1:0];
          if (pwdata[`CFF_C_LEGACY_UPG])
            ev[`CFF_I_UPG_REFUSE] = 1'b1;
          if (pwdata[`CFF_C_UPDATE])
            r_d.upd = 1'b1;
          // a restart request is refused while an update is running, but not in the write that sets the update bit
          if (pwdata[`CFF_C_RESTART] && !r_q.upd && !daisy
              && r_q.st != S_IDLE)
          begin
            r_d.st        = S_RESTART;
            r_d.restart_n = 1'b0;
            r_d.cnt       = 16'(RESTART_CYC - 1);
            r_d.wv        = 1'b0;
          end
        end
        `CFF_IRQ_ADDR:  r_d.irq  = r_q.irq & ~pwdata[`CFF_IRQ_W-1:0];
        `CFF_MASK_ADDR: r_d.mask = pwdata[`CFF_IRQ_W-1:0];
        default:        r_d.irq  = r_d.irq;
      endcase
    end

    if (fabric_update_done)
      r_d.upd = 1'b0;
    if (!r_d.ctrl[`CFF_C_EN])
    begin
      r_d.st        = S_IDLE;
      r_d.restart_n = 1'b1;
    end
    // a new event wins over a clear in the same cycle
    r_d.irq = r_d.irq | ev;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      r_q           <= '0;
      r_q.st        <= S_IDLE;
      r_q.ctrl      <= `CFF_CTRL_RST;
      r_q.irq       <= `CFF_IRQ_RST;
      r_q.restart_n <= 1'b1;
      r_q.hb_rst    <= 1'b1;
    end
    else
      r_q <= r_d;
  end

endmodule

// File: rtl/sync2.sv
// two-flip-flop synchroniser for a group of independent levels;
// assumes each bit is a slow level or is qualified after sync.
`timescale 1ns/1ps

module sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_q;

  initial
  begin
    if (WIDTH < 1)
      $error("sync2: WIDTH must be at least 1");
  end

  // meta_q feeds only the second stage
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta_q <= '0;
      q      <= '0;
    end
    else
    begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule

// File: rtl/word_serializer.sv
// drives a passive configuration clock and data out, one clock
// pulse per bit, or per word in parallel mode; assumes clk is the fabric clock.
`timescale 1ns/1ps

module word_serializer #(
  parameter int W    = 8,
  parameter int HALF = 2
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         parallel,
  input  wire logic         load_valid,
  input  wire logic [W-1:0] load_data,
  output logic              load_ready,
  output logic              cfg_clk,
  output logic [W-1:0]      cfg_data
);

  typedef struct packed {
    logic         busy;
    logic         hi;
    logic [15:0]  cnt;
    logic [7:0]   left;
    logic [W-1:0] sh;
    logic         par;
  } ser_t;

  ser_t r_q;
  ser_t r_d;

  initial
  begin
    if (W < 1 || W > 255 || HALF < 1 || HALF > 65535)
      $error("word_serializer: W or HALF out of range");
  end

  assign load_ready = !r_q.busy;
  assign cfg_clk    = r_q.hi;
  // serial mode presents the low bit on data line 0
  assign cfg_data   = r_q.par ? r_q.sh : {{(W-1){1'b0}}, r_q.sh[0]};

  always_comb
  begin
    r_d = r_q;
    if (!r_q.busy)
    begin
      if (load_valid)
      begin
        r_d.busy = 1'b1;
        r_d.hi   = 1'b0;
        r_d.sh   = load_data;
        r_d.par  = parallel;
        r_d.left = parallel ? 8'h01 : 8'(W);
        r_d.cnt  = 16'(HALF - 1);
      end
    end
    else if (r_q.cnt != 16'h0000)
    begin
      r_d.cnt = r_q.cnt - 16'h0001;
    end
    else if (!r_q.hi)
    begin
      // data has been stable a half period: raise the clock
      r_d.hi  = 1'b1;
      r_d.cnt = 16'(HALF - 1);
    end
    else
    begin
      r_d.hi   = 1'b0;
      r_d.cnt  = 16'(HALF - 1);
      r_d.sh   = r_q.sh >> 1;
      r_d.left = r_q.left - 8'h01;
      if (r_q.left == 8'h01)
        r_d.busy = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      r_q <= '0;
    else
      r_q <= r_d;
  end

endmodule

// File: tb/cfg_fwd_asserts.sv
// pin-level checker for the configuration chain forwarder
// assumes it is bound to the forwarder top with its parameters
`timescale 1ns/1ps

module cfg_fwd_asserts #(
  parameter int DW          = 8,
  parameter int RESTART_CYC = 2
) (
  input wire logic          clk,
  input wire logic          rst,
  input wire logic          ep_ready,
  input wire logic [DW-1:0] rc_tx_data,
  input wire logic          rc_tx_valid,
  input wire logic          rc_tx_ready,
  input wire logic          slave_cfg_clk_out,
  input wire logic [DW-1:0] slave_data_out,
  input wire logic          slave_restart_out_n,
  input wire logic          slave_enable_out_n,
  input wire logic          own_fabric_done,
  input wire logic          fabric_update_done,
  input wire logic          key_valid,
  input wire logic          decrypt_en,
  input wire logic          fabric_load_complete,
  input wire logic          pcie_fundamental_reset_n,
  input wire logic          hard_block_rst,
  input wire logic          user_pin_in
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // ***********************************
  // restart low-time counter
  // ***********************************
  logic [15:0] low_cnt_q;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      low_cnt_q <= 16'h0000;
    else if (!slave_restart_out_n)
      low_cnt_q <= low_cnt_q + 16'h0001;
    else
      low_cnt_q <= 16'h0000;
  end

  restart_len_a: assert property
    ($rose(slave_restart_out_n) |-> low_cnt_q == RESTART_CYC)
    else $error("restart pulse length wrong");
  restart_quiet_a: assert property
    (!slave_restart_out_n |-> !slave_cfg_clk_out)
    else $error("config clock runs during restart");
  data_hold_a: assert property
    (slave_cfg_clk_out |-> $stable(slave_data_out))
    else $error("slave data moved while clock high");
  daisy_pins_a: assert property
    (rc_tx_valid |-> slave_restart_out_n && slave_enable_out_n)
    else $error("slave pins active in daisy mode");
  tx_hold_a: assert property
    (rc_tx_valid && !rc_tx_ready |=> rc_tx_valid && $stable(rc_tx_data))
    else $error("root word dropped before accept");
  tx_busy_a: assert property
    (rc_tx_valid |-> !ep_ready)
    else $error("endpoint ready while word pending");
  tx_after_fabric_a: assert property
    (rc_tx_valid |-> fabric_load_complete)
    else $error("next device fed before own fabric done");
  load_low_a: assert property
    (!own_fabric_done |-> !fabric_load_complete)
    else $error("load complete high while loading");
  update_end_a: assert property
    (fabric_update_done && own_fabric_done ##1 own_fabric_done
      |-> fabric_load_complete)
    else $error("load complete not back after update");
  hb_hold_a: assert property
    (!pcie_fundamental_reset_n [*4] |-> hard_block_rst)
    else $error("hard block not held in reset");
  pin_follow_a: assert property
    (pcie_fundamental_reset_n [*3] |-> user_pin_in)
    else $error("user pin does not follow reset pin");
  decrypt_key_a: assert property
    (decrypt_en |-> key_valid)
    else $error("decrypt without key");
endmodule

bind pcie_config_chain_forwarder cfg_fwd_asserts #(
  .DW(DW), .RESTART_CYC(RESTART_CYC)) chk_i (.*);

// File: tb/pcie_config_chain_forwarder_bench.sv
// self-checking bench for the configuration chain forwarder
// assumes the defs header is on the include path
`timescale 1ns/1ps
`include "cfg_fwd_defs.svh"

module pcie_config_chain_forwarder_bench;
  import cfg_fwd_pkg::*;
  localparam logic [11:0] CT = `CFF_CTRL_ADDR, ST = `CFF_STAT_ADDR;
  localparam logic [11:0] IQ = `CFF_IRQ_ADDR, MK = `CFF_MASK_ADDR;
  localparam logic [31:0] EN = 32'h1 << `CFF_C_EN,
    DSY = 32'h1 << `CFF_C_DAISY, PAR = 32'h1 << `CFF_C_PARALLEL,
    CMP = 32'h1 << `CFF_C_COMPRESS, ENC = 32'h1 << `CFF_C_ENCRYPT,
    FAB = 32'h1 << `CFF_C_FABRIC, HBU = 32'h1 << `CFF_C_HB_UNUSED,
    UPD = 32'h1 << `CFF_C_UPDATE, LEG = 32'h1 << `CFF_C_LEGACY_UPG;

  logic clk, rst, psel, penable, pwrite, pready, pslverr, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv, refusals [3];
  logic ep_clk, ep_valid, ep_ready, rc_tx_valid, rc_tx_ready, errv;
  logic [7:0] ep_data, rc_tx_data, slave_data_out;
  logic slave_cfg_clk_out, slave_restart_out_n, slave_enable_out_n;
  logic cfg_status_n, cfg_complete, own_fabric_done, fabric_update_done;
  logic key_valid, decrypt_en, fabric_load_complete, hard_block_rst;
  logic pcie_fundamental_reset_n, user_pin_in, parallel, slave_err;
  int fail_count, n_tests, i;

  pcie_config_chain_forwarder #(.RESTART_CYC(2)) DUT (.*);
  slave_chain_model sm (.slave_cfg_clk_out, .slave_data_out,
    .slave_restart_out_n, .slave_enable_out_n, .parallel, .slave_err,
    .cfg_status_n, .cfg_complete);

  // ***********************************
  // access and compare tasks
  // ***********************************
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask

  // entered just after a rising edge; leaves one idle cycle behind
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rdm(input string nm, input logic [11:0] a,
                     input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rdv & m);
  endtask

  task automatic wstate(input logic [2:0] s);
    for (int k = 0; k < 100; k++)
    begin
      apb(1'b0, ST, 32'h0);
      if (rdv[2:0] === s)
        break;
    end
    chk("state", {29'h0, s}, {29'h0, rdv[2:0]});
  endtask

  // one word per link clock period, clock rising with valid and falling before it
  task automatic send(input logic [7:0] d);
    for (int k = 0; k < 100 && ep_ready !== 1'b1; k++)
      @(posedge clk);
    ep_data <= d;
    ep_valid <= 1'b1;
    ep_clk <= 1'b1;
    repeat (4) @(posedge clk);
    ep_clk <= 1'b0;
    repeat (4) @(posedge clk);
    ep_valid <= 1'b0;
    ep_data <= ~d;
    @(posedge clk);
  endtask

  task automatic getw(input logic [7:0] e);
    for (int k = 0; k < 300 && sm.n_words == 0; k++)
      @(posedge clk);
    // done flag needs two sync stages and an edge detect
    repeat (4) @(posedge clk);
    chk("slave word", {24'h0, e}, {24'h0, sm.last_word});
  endtask

  task conclude;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial
  begin
    #2_000_000;
    fail_count++;
    conclude;
  end

  // ***********************************
  // test sequence
  // ***********************************
  initial
  begin
    {rst, psel, penable, pwrite, ep_clk, ep_valid, rc_tx_ready} = 7'h40;
    {own_fabric_done, fabric_update_done, key_valid} = 3'h0;
    {pcie_fundamental_reset_n, parallel, slave_err} = 3'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    ep_data = 8'h00;
    fail_count = 0;
    n_tests = 0;
    refusals = '{EN | CMP, EN | ENC, EN | FAB | ENC};
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("hb rst", 1, hard_block_rst);
    rdm("ctrl", CT, 32'hffffffff, 0);
    rdm("irq", IQ, 32'hffffffff, 0);
    rdm("mask", MK, 32'hffffffff, 0);
    rdm("state", ST, 32'h7, 0);
    rdm("unmapped", 12'h010, 32'hffffffff, 0);
    chk("slverr", 1, errv);
    pcie_fundamental_reset_n <= 1'b1;
    repeat (5) @(posedge clk);
    chk("hb rst", 0, hard_block_rst);
    chk("pin", 1, user_pin_in);
    apb(1'b1, CT, HBU);
    pcie_fundamental_reset_n <= 1'b0;
    repeat (5) @(posedge clk);
    chk("pin", 0, user_pin_in);
    pcie_fundamental_reset_n <= 1'b1;
    repeat (5) @(posedge clk);
    chk("hb unused", 1, hard_block_rst);
    apb(1'b1, CT, 32'h0);
    $display("reset test done");

    apb(1'b1, MK, 32'h3f);
    for (i = 0; i < 3; i++)
    begin
      apb(1'b1, CT, refusals[i]);
      rdm("refused", IQ, 32'h10, 32'h10);
      chk("irq", 1, irq);
      rdm("idle", ST, 32'h7, 0);
      apb(1'b1, IQ, 32'h10);
      chk("irq clr", 0, irq);
      apb(1'b1, CT, 32'h0);
    end
    apb(1'b1, MK, 32'h0);
    apb(1'b1, CT, EN | CMP);
    rdm("masked", IQ, 32'h10, 32'h10);
    chk("irq mask", 0, irq);
    apb(1'b1, IQ, 32'h3f);
    apb(1'b1, CT, 32'h0);
    $display("refusal test done");

    key_valid <= 1'b1;
    parallel <= 1'b1;
    apb(1'b1, CT, EN | PAR | FAB | ENC);
    wstate(3'h4);
    chk("enable", 0, slave_enable_out_n);
    chk("decrypt", 1, decrypt_en);
    send(8'ha5);
    getw(8'ha5);
    rdm("slave done", IQ, 32'h3, 32'h3);
    slave_err <= 1'b1;
    wstate(3'h2);
    rdm("slave err", IQ, 32'h4, 32'h4);
    slave_err <= 1'b0;
    wstate(3'h4);
    apb(1'b1, CT, 32'h0);
    parallel <= 1'b0;
    apb(1'b1, CT, EN | FAB);
    wstate(3'h4);
    send(8'h3c);
    getw(8'h3c);
    apb(1'b1, CT, 32'h0);
    apb(1'b1, IQ, 32'h3f);
    $display("mixed chain test done");

    chk("load low", 0, fabric_load_complete);
    apb(1'b1, CT, EN | DSY | FAB);
    wstate(3'h3);
    own_fabric_done <= 1'b1;
    wstate(3'h4);
    chk("load done", 1, fabric_load_complete);
    chk("restart", 1, slave_restart_out_n);
    chk("enable", 1, slave_enable_out_n);
    send(8'h5a);
    for (i = 0; i < 50 && rc_tx_valid !== 1'b1; i++)
      @(posedge clk);
    repeat (5) @(posedge clk);
    chk("tx valid", 1, rc_tx_valid);
    chk("tx data", 32'h5a, {24'h0, rc_tx_data});
    rc_tx_ready <= 1'b1;
    for (i = 0; i < 50 && rc_tx_valid !== 1'b0; i++)
      @(posedge clk);
    rc_tx_ready <= 1'b0;
    rdm("handed on", IQ, 32'h1, 32'h1);
    $display("daisy chain test done");

    apb(1'b1, CT, EN | DSY | FAB | UPD);
    chk("update low", 0, fabric_load_complete);
    chk("restart", 1, slave_restart_out_n);
    fabric_update_done <= 1'b1;
    @(posedge clk);
    fabric_update_done <= 1'b0;
    repeat (2) @(posedge clk);
    chk("update end", 1, fabric_load_complete);
    apb(1'b1, CT, EN | DSY | FAB | LEG);
    rdm("legacy", IQ, 32'h20, 32'h20);
    apb(1'b1, IQ, 32'h3f);
    rdm("irq clr", IQ, 32'h3f, 0);
    $display("update test done");
    conclude;
  end
endmodule

// File: tb/slave_chain_model.sv
// behavioural chain of passive slaves on the forwarder's pins
// assumes all slaves share clock, data, restart and status lines
`timescale 1ns/1ps

module slave_chain_model (
  input  wire logic       slave_cfg_clk_out,
  input  wire logic [7:0] slave_data_out,
  input  wire logic       slave_restart_out_n,
  input  wire logic       slave_enable_out_n,
  input  wire logic       parallel,
  input  wire logic       slave_err,
  output logic            cfg_status_n,
  output logic            cfg_complete
);
  logic [7:0] last_word;
  logic [7:0] sh;
  int         n_words = 0;
  int         bits = 0;
  logic       init_busy = 1'b0;

  // slaves need a while after restart before they report ready
  always @(posedge slave_restart_out_n)
  begin
    init_busy = 1'b1;
    #300 init_busy = 1'b0;
  end

  // shared status line with pull-up: low while any slave holds it
  assign cfg_status_n = !(slave_err || !slave_restart_out_n || init_busy);
  assign cfg_complete = (n_words != 0);

  always @(posedge slave_cfg_clk_out or negedge slave_restart_out_n
           or posedge slave_err)
  begin
    if (!slave_restart_out_n || slave_err)
    begin
      n_words = 0;
      bits = 0;
    end
    else if (!slave_enable_out_n) // last chain output left open
    begin
      sh = {slave_data_out[0], sh[7:1]};
      bits = parallel ? 8 : bits + 1; // scheme strap
      if (bits == 8)
      begin
        last_word = parallel ? slave_data_out : sh;
        n_words++;
        bits = 0;
      end
    end
  end
endmodule
